// File: design/pdc_pkg.sv
// Behaviour
// - Fraction multiplier is six high bits joined with the eight-bit low byte.
// - Integer multiplier is one high bit plus low byte; low byte resets 8.
// - N divider code in bits 7:5 is its ratio, zero means eight.
// - Density divider code 0 to 4 gives 1,2,4,8,16; 5 to 7 reserved.
// - M divider code in bits 7:2 is its ratio, zero means 64.
// - ADC modulator divider bits 1:0 give 1,2,4; code 3 reserved.
// - DAC modulator divider bits 5:4 give 1,2,4; code 3 reserved.
// - Bit 2 of last register is top bit of primary bit clock divider.
// - Bit 1 of last register is top bit of secondary bit clock divider.
// - With automatic clock detection on, all these fields are ignored.
// - Integer top bit from bit 7, fraction top bits from 5:0 before.
// - Bit clock low byte joins top bit; combined zero means ratio 512.
// - N, M and density run flags follow their enable bits one clock later.
package pdc_pkg;
    localparam logic [7:0] PDC_ADDR_FRAC_LO = 8'h37;
    localparam logic [7:0] PDC_ADDR_INT_LO = 8'h38;
    localparam logic [7:0] PDC_ADDR_ND = 8'h39;
    localparam logic [7:0] PDC_ADDR_MA = 8'h3a;
    localparam logic [7:0] PDC_ADDR_DB = 8'h3b;
    localparam logic [7:0] PDC_RST_FRAC_LO = 8'h00;
    localparam logic [7:0] PDC_RST_INT_LO = 8'h08;
    localparam logic [7:0] PDC_RST_ND = 8'h20;
    localparam logic [7:0] PDC_RST_MA = 8'h04;
    localparam logic [7:0] PDC_RST_DB = 8'h00;
    // Writable bits of the last register; bit 0 is read-only zero
    localparam logic [7:0] PDC_MASK_DB = 8'hfe;
    localparam int PDC_N_MSB = 7;
    localparam int PDC_N_LSB = 5;
    localparam int PDC_D_MSB = 4;
    localparam int PDC_D_LSB = 2;
    localparam int PDC_M_MSB = 7;
    localparam int PDC_M_LSB = 2;
    localparam int PDC_A_MSB = 1;
    localparam int PDC_A_LSB = 0;
    localparam int PDC_DAC_MSB = 5;
    localparam int PDC_DAC_LSB = 4;
    localparam int PDC_PBIT = 2;
    localparam int PDC_SBIT = 1;
    localparam int PDC_INT_HI_BIT = 7;
    localparam int PDC_FRAC_HI_MSB = 5;
    localparam logic [3:0] PDC_N_ZERO_RATIO = 4'h8;
    localparam logic [6:0] PDC_M_ZERO_RATIO = 7'h40;
    localparam logic [9:0] PDC_B_ZERO_RATIO = 10'h200;

    typedef struct packed {
        logic [13:0] frac_mul;
        logic [8:0] int_mul;
        logic [3:0] n_ratio;
        logic [6:0] m_ratio;
        logic [4:0] density_ratio;
        logic [2:0] adc_ratio;
        logic [2:0] dac_ratio;
        logic [9:0] pbit_ratio;
        logic [9:0] sbit_ratio;
    } pdc_cfg_s;
endpackage

// File: design/pdc_ratio_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_ratio_decode (
    input wire logic [7:0] i_nd,
    input wire logic [7:0] i_ma,
    input wire logic [7:0] i_db,
    input wire logic [7:0] i_pb_low,
    input wire logic [7:0] i_sb_low,
    output logic [3:0] o_n_ratio,
    output logic [6:0] o_m_ratio,
    output logic [4:0] o_density_ratio,
    output logic [2:0] o_adc_ratio,
    output logic [2:0] o_dac_ratio,
    output logic [9:0] o_pbit_ratio,
    output logic [9:0] o_sbit_ratio
);
    // Two-bit modulator code: 1,2,4; reserved code gives zero
    function automatic logic [2:0] mod_ratio(input logic [1:0] c);
        mod_ratio = (c == 2'h3) ? 3'h0 : 3'(3'h1 << c);
    endfunction

    // Zero code on a bit clock divider means 512
    function automatic logic [9:0] bit_ratio(input logic top,
                                             input logic [7:0] low);
        bit_ratio = ({top, low} == 9'h000) ? pdc_pkg::PDC_B_ZERO_RATIO
                                             : {1'b0, top, low};
    endfunction

    logic [2:0] n_code;
    logic [5:0] m_code;
    logic [2:0] d_code;
    assign n_code = i_nd[pdc_pkg::PDC_N_MSB:pdc_pkg::PDC_N_LSB];
    assign m_code = i_ma[pdc_pkg::PDC_M_MSB:pdc_pkg::PDC_M_LSB];
    assign d_code = i_nd[pdc_pkg::PDC_D_MSB:pdc_pkg::PDC_D_LSB];

    assign o_n_ratio = (n_code == 3'h0) ? pdc_pkg::PDC_N_ZERO_RATIO
                                        : {1'b0, n_code};
    assign o_m_ratio = (m_code == 6'h00) ? pdc_pkg::PDC_M_ZERO_RATIO
                                         : {1'b0, m_code};
    assign o_density_ratio = (d_code > 3'h4) ? 5'h00 : 5'(5'h01 << d_code);
    assign o_adc_ratio =
        mod_ratio(i_ma[pdc_pkg::PDC_A_MSB:pdc_pkg::PDC_A_LSB]);
    assign o_dac_ratio =
        mod_ratio(i_db[pdc_pkg::PDC_DAC_MSB:pdc_pkg::PDC_DAC_LSB]);
    assign o_pbit_ratio = bit_ratio(i_db[pdc_pkg::PDC_PBIT], i_pb_low);
    assign o_sbit_ratio = bit_ratio(i_db[pdc_pkg::PDC_SBIT], i_sb_low);
endmodule
`default_nettype wire

// File: design/pdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_top (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_hit,
    input wire logic i_auto_detect,
    input wire logic [7:0] i_pre_reg,
    input wire logic [7:0] i_pbit_low,
    input wire logic [7:0] i_sbit_low,
    input wire logic i_n_divider_on,
    input wire logic i_m_divider_on,
    input wire logic i_density_divider_on,
    input wire pdc_pkg::pdc_cfg_s i_auto_cfg,
    output pdc_pkg::pdc_cfg_s o_cfg,
    output logic o_n_run,
    output logic o_m_run,
    output logic o_density_run
);
    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0] frac_lo_q, frac_lo_d;
    logic [7:0] int_lo_q, int_lo_d;
    logic [7:0] nd_q, nd_d;
    logic [7:0] ma_q, ma_d;
    logic [7:0] db_q, db_d;

    always_comb begin
        frac_lo_d = frac_lo_q;
        int_lo_d = int_lo_q;
        nd_d = nd_q;
        ma_d = ma_q;
        db_d = db_q;
        if (i_wr_en) begin
            case (i_addr)
                pdc_pkg::PDC_ADDR_FRAC_LO: frac_lo_d = i_wdata;
                pdc_pkg::PDC_ADDR_INT_LO: int_lo_d = i_wdata;
                pdc_pkg::PDC_ADDR_ND: nd_d = i_wdata;
                pdc_pkg::PDC_ADDR_MA: ma_d = i_wdata;
                pdc_pkg::PDC_ADDR_DB: db_d = i_wdata & pdc_pkg::PDC_MASK_DB;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            frac_lo_q <= pdc_pkg::PDC_RST_FRAC_LO;
            int_lo_q <= pdc_pkg::PDC_RST_INT_LO;
            nd_q <= pdc_pkg::PDC_RST_ND;
            ma_q <= pdc_pkg::PDC_RST_MA;
            db_q <= pdc_pkg::PDC_RST_DB;
        end else begin
            frac_lo_q <= frac_lo_d;
            int_lo_q <= int_lo_d;
            nd_q <= nd_d;
            ma_q <= ma_d;
            db_q <= db_d;
        end
    end

    // Combinational read; unmapped addresses read zero
    always_comb begin
        o_hit = 1'b1;
        case (i_addr)
            pdc_pkg::PDC_ADDR_FRAC_LO: o_rdata = frac_lo_q;
            pdc_pkg::PDC_ADDR_INT_LO: o_rdata = int_lo_q;
            pdc_pkg::PDC_ADDR_ND: o_rdata = nd_q;
            pdc_pkg::PDC_ADDR_MA: o_rdata = ma_q;
            pdc_pkg::PDC_ADDR_DB: o_rdata = db_q;
            default: begin
                o_rdata = 8'h00;
                o_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Field decode
    // ==========================================================
    pdc_pkg::pdc_cfg_s man_cfg, cfg_d, cfg_q;

    assign man_cfg.frac_mul =
        {i_pre_reg[pdc_pkg::PDC_FRAC_HI_MSB:0], frac_lo_q};
    assign man_cfg.int_mul = {i_pre_reg[pdc_pkg::PDC_INT_HI_BIT], int_lo_q};

    pdc_ratio_decode u_dec (
        .i_nd(nd_q),
        .i_ma(ma_q),
        .i_db(db_q),
        .i_pb_low(i_pbit_low),
        .i_sb_low(i_sbit_low),
        .o_n_ratio(man_cfg.n_ratio),
        .o_m_ratio(man_cfg.m_ratio),
        .o_density_ratio(man_cfg.density_ratio),
        .o_adc_ratio(man_cfg.adc_ratio),
        .o_dac_ratio(man_cfg.dac_ratio),
        .o_pbit_ratio(man_cfg.pbit_ratio),
        .o_sbit_ratio(man_cfg.sbit_ratio)
    );

    always_comb begin
        cfg_d = i_auto_detect ? i_auto_cfg : man_cfg;
    end

    logic n_run_d, m_run_d, d_run_d;
    always_comb begin
        n_run_d = i_n_divider_on;
        m_run_d = i_m_divider_on;
        d_run_d = i_density_divider_on;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cfg_q <= '0;
            o_n_run <= 1'b0;
            o_m_run <= 1'b0;
            o_density_run <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            o_n_run <= n_run_d;
            o_m_run <= m_run_d;
            o_density_run <= d_run_d;
        end
    end
    assign o_cfg = cfg_q;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    chk_db_bit0_zero: assert property (db_q[0] == 1'b0)
        else $error("read-only bit of last register set");
    chk_int_reset_val: assert property ($fell(i_srst)
        |-> int_lo_q == pdc_pkg::PDC_RST_INT_LO)
        else $error("integer low byte reset wrong");
    chk_int_concat: assert property (!i_auto_detect ##1 !$past(i_auto_detect)
        |-> o_cfg.int_mul == {$past(i_pre_reg[7]), $past(int_lo_q)})
        else $error("integer multiplier not concatenated");
    chk_frac_concat: assert property (!i_auto_detect
        |=> o_cfg.frac_mul == {$past(i_pre_reg[5:0]), $past(frac_lo_q)})
        else $error("fraction multiplier not concatenated");
    chk_n_zero_eight: assert property (!i_auto_detect && nd_q[7:5] == 3'h0
        |=> o_cfg.n_ratio == 4'h8)
        else $error("n code zero not eight");
    chk_m_zero_64: assert property (!i_auto_detect && ma_q[7:2] == 6'h00
        |=> o_cfg.m_ratio == 7'h40)
        else $error("m code zero not 64");
    chk_density_code: assert property (!i_auto_detect && nd_q[4:2] == 3'h4
        |=> o_cfg.density_ratio == 5'h10)
        else $error("density code four not 16");
    chk_adc_code: assert property (!i_auto_detect && ma_q[1:0] == 2'h2
        |=> o_cfg.adc_ratio == 3'h4)
        else $error("adc code two not four");
    chk_dac_code: assert property (!i_auto_detect && db_q[5:4] == 2'h1
        |=> o_cfg.dac_ratio == 3'h2)
        else $error("dac code one not two");
    chk_pbit_top: assert property (!i_auto_detect && db_q[2]
        |=> o_cfg.pbit_ratio[8])
        else $error("primary top bit lost");
    chk_sbit_top: assert property (!i_auto_detect && db_q[1]
        |=> o_cfg.sbit_ratio[8])
        else $error("secondary top bit lost");
    chk_bit_zero_512: assert property (!i_auto_detect && !db_q[2]
        && i_pbit_low == 8'h00 |=> o_cfg.pbit_ratio == 10'h200)
        else $error("primary zero not 512");
    chk_auto_passes: assert property (i_auto_detect
        |=> o_cfg == $past(i_auto_cfg))
        else $error("auto config not used");
    chk_n_enable: assert property (!i_n_divider_on |=> !o_n_run)
        else $error("n divider runs while off");
endmodule
`default_nettype wire

// File: tb/pdc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_top_tb;
    logic i_core_clk, i_srst, i_wr_en, i_auto_detect;
    logic [7:0] i_addr, i_wdata, i_pre_reg, i_pbit_low, i_sbit_low, o_rdata;
    logic i_n_divider_on, i_m_divider_on, i_density_divider_on;
    logic o_hit, o_n_run, o_m_run, o_density_run;
    pdc_pkg::pdc_cfg_s i_auto_cfg, o_cfg;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    pdc_top pdc_top_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_hit(o_hit), .i_auto_detect(i_auto_detect),
        .i_pre_reg(i_pre_reg), .i_pbit_low(i_pbit_low),
        .i_sbit_low(i_sbit_low), .i_n_divider_on(i_n_divider_on),
        .i_m_divider_on(i_m_divider_on),
        .i_density_divider_on(i_density_divider_on),
        .i_auto_cfg(i_auto_cfg), .o_cfg(o_cfg), .o_n_run(o_n_run),
        .o_m_run(o_m_run), .o_density_run(o_density_run));
    // ==========================================
    // Clock, timeout and reporting
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    // Whole run is about a hundred cycles; ceiling of 3000 leaves ample margin
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_v(input logic [15:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_cfg(input pdc_pkg::pdc_cfg_s exp, input string msg);
        samples_checked++;
        if (o_cfg !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, o_cfg, exp);
        end
    endtask
    // ==========================================
    // Register access
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_core_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
    endtask
    // Registered outputs settle one edge after the write edge
    task automatic settle();
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, exp, input logic hit);
        @(posedge i_core_clk);
        i_addr <= a;
        #1;
        chk_v(16'(o_rdata), 16'(exp), "read data");
        chk_v(16'(o_hit), 16'(hit), "address hit");
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset(input string name);
        logic [7:0] rv [5];
        rv = '{8'h00, 8'h08, 8'h20, 8'h04, 8'h00};
        for (int i = 0; i < 5; i++)
            rd(8'h37 + 8'(i), rv[i], 1'b1); // reset values
        rd(8'h3c, 8'h00, 1'b0); // outside group reads zero
        chk_cfg('{14'h0000, 9'h008, 4'h1, 7'h01, 5'h01, 3'h1, 3'h1,
            10'h001, 10'h200}, "reset cfg"); // zero means 512
        chk_v(16'({o_n_run, o_m_run, o_density_run}), 16'h0000, "run");
        $display("test %s done", name);
    endtask
    task automatic t_fields();
        @(posedge i_core_clk);
        // fraction 0x260f stays below the reserved range
        i_pre_reg <= 8'ha6;
        wr(8'h37, 8'h0f);
        wr(8'h38, 8'hff);
        wr(8'h39, 8'h10);
        wr(8'h3a, 8'h02);
        // reserved bits written with their reset values
        wr(8'h3b, 8'h36);
        // Stray writes around the block must not land
        wr(8'h36, 8'hff);
        wr(8'h3c, 8'hff);
        settle();
        chk_cfg('{14'h260f, 9'h1ff, 4'h8, 7'h40, 5'h10, 3'h4, 3'h0,
            10'h101, 10'h100}, "fields");
        rd(8'h3b, 8'h36, 1'b1); // written value reads back
        rd(8'h38, 8'hff, 1'b1); // low byte stored
        $display("test fields done");
    endtask
    task automatic t_codes();
        for (int c = 0; c < 8; c++) begin
            wr(8'h39, {3'b111, 3'(c), 2'b00});
            settle();
            chk_v(16'(o_cfg.density_ratio), (c < 5) ? 16'(1 << c) : 16'h0000,
                "density"); // density codes
            chk_v(16'(o_cfg.n_ratio), 16'h0007, "n ratio"); // plain code
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h3a, {6'h3f, 2'(c)});
            wr(8'h3b, {2'b00, 2'(c), 4'h0});
            settle();
            chk_v(16'(o_cfg.adc_ratio), (c < 3) ? 16'(1 << c) : 16'h0000,
                "adc"); // adc codes
            chk_v(16'(o_cfg.dac_ratio), (c < 3) ? 16'(1 << c) : 16'h0000,
                "dac"); // dac codes
            chk_v(16'(o_cfg.m_ratio), 16'h003f, "m ratio"); // plain code
        end
        $display("test codes done");
    endtask
    task automatic t_auto();
        pdc_pkg::pdc_cfg_s a;
        a = '{14'h2a5c, 9'h0c3, 4'h5, 7'h2b, 5'h04, 3'h2, 3'h4,
            10'h2d1, 10'h13e};
        @(posedge i_core_clk);
        i_auto_cfg <= a;
        i_auto_detect <= 1'b1;
        wr(8'h39, 8'h00);
        settle();
        chk_cfg(a, "auto cfg"); // fields ignored
        @(posedge i_core_clk);
        i_auto_detect <= 1'b0;
        settle();
        chk_v(16'(o_cfg.n_ratio), 16'h0008, "n zero"); // zero means eight
        chk_v(16'(o_cfg.density_ratio), 16'h0001, "density zero");
        $display("test auto done");
    endtask
    task automatic t_run();
        for (int p = 0; p < 8; p++) begin
            @(posedge i_core_clk);
            {i_n_divider_on, i_m_divider_on, i_density_divider_on} <= 3'(p);
            settle();
            chk_v(16'({o_n_run, o_m_run, o_density_run}), 16'(p),
                "run"); // enables gate dividers
        end
        $display("test run done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        i_srst = 1'b1;
        i_wr_en = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_auto_detect = 1'b0;
        i_pre_reg = 8'h00;
        i_pbit_low = 8'h01;
        i_sbit_low = 8'h00;
        {i_n_divider_on, i_m_divider_on, i_density_divider_on} = 3'h0;
        i_auto_cfg = '0;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        t_reset("reset");
        t_fields();
        t_codes();
        t_auto();
        t_run();
        // Mid-run reset must restore every register
        @(posedge i_core_clk);
        i_pre_reg <= 8'h00;
        {i_n_divider_on, i_m_divider_on, i_density_divider_on} <= 3'h0;
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        t_reset("second reset");
        test_done();
    end
endmodule
`default_nettype wire
